// ---- rtc_backup_domain.sv ----
// RTC backup domain: counters, calibration, alarm, supply and charger control
//
// Notes on behaviour
// - Charger on: enabled, battery above, backup low; in off mode only with keep bit
// - Charge ok and lost flags, maskable
// - System rail source priority: battery, charger, vbus, backup
// - RTC rail select from supply, force, reset
// - 21-bit sub-minute counter, top 16 visible
// - 24-bit minutes counter, one per minute
// - Signed 7-bit calibration applied each minute
// - Step one slow period, limit 127 periods
// - Latched maskable tick interrupt each minute
// - 24-bit alarm compared against minutes counter
// - Enabled alarm interrupts; wakes device when off
// - Power-up cause records alarm wake
// - Both slow outputs in operating mode; out2 disable
// - Read request copies counters, then clears
// - Five ordered writes load the counters
// - Supply fail marker cleared only by reset
// - Status shows crystal or RC slow clock
// - Domain registers reset by RTC power-on reset
`include "rtc_defs.svh"
`default_nettype none
module rtc_backup_domain #(
  parameter int unsigned MINUTE_TICKS = `RTC_MINUTE_TICKS
) (
  // Clock and RTC power-on reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // Register port
  input  wire logic [4:0]            addr,
  input  wire logic [7:0]            wdata,
  input  wire logic                  wstb,
  input  wire logic                  rstb,
  output logic [7:0]                 rdata,
  // Slow clock and supply pins
  input  wire logic                  slow_clock,
  input  wire logic                  rtc_supply_por_n,
  input  wire logic                  system_supply_por_n,
  input  wire logic                  battery_por_n,
  input  wire logic                  main_charger_detect,
  input  wire logic                  vbus_detect,
  input  wire logic                  operating_mode,
  input  wire logic                  xtal_selected,
  // Backup battery comparators
  input  wire logic                  main_above_backup,
  input  wire logic                  backup_below_threshold,
  input  wire logic                  backup_at_level,
  input  wire logic                  backup_below_hyst,
  // Outputs
  output rtc_pkg::supply_sel_t       rtc_supply_sel,
  output rtc_pkg::system_source_t    system_source,
  output logic                       charger_on,
  output logic                       charger_low_power,
  output logic                       slow_clock_out1,
  output logic                       slow_clock_out2,
  output logic                       power_on_req,
  output logic                       host_irq_n
);
  import rtc_pkg::*;

  // ----------------------------------------------------------------
  // Slow clock sampling and pin synchronisers
  // ----------------------------------------------------------------
  slow_tick_if tick_bus ();

  slow_clock_sampler sampler (
    .clock      (clock),
    .rst        (rst),
    .slow_clock (slow_clock),
    .tick_o     (tick_bus)
  );

  localparam int PINS = 11;
  logic [PINS-1:0] pins_raw;
  logic [PINS-1:0] pins_s1_q;
  logic [PINS-1:0] pins_s2_q;
  logic [PINS-1:0] pins_s3_q;

  assign pins_raw = {xtal_selected, backup_below_hyst, backup_at_level, backup_below_threshold,
                     main_above_backup, operating_mode, vbus_detect, main_charger_detect,
                     battery_por_n, system_supply_por_n, rtc_supply_por_n};

  // Two flops before use; s3 only feeds the edge finders
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pins_s1_q <= '0;
      pins_s2_q <= '0;
      pins_s3_q <= '0;
    end else begin
      pins_s1_q <= pins_raw;
      pins_s2_q <= pins_s1_q;
      pins_s3_q <= pins_s2_q;
    end
  end

  wire rtc_por_ok  = pins_s2_q[0];
  wire sys_good    = pins_s2_q[1];
  wire bat_ok      = pins_s2_q[2];
  wire chg_det     = pins_s2_q[3];
  wire vbus_det    = pins_s2_q[4];
  wire op_mode     = pins_s2_q[5];
  wire bat_above   = pins_s2_q[6];
  wire bup_low     = pins_s2_q[7];
  wire reach_ev    = pins_s2_q[8] & ~pins_s3_q[8];
  wire lost_ev     = pins_s2_q[9] & ~pins_s3_q[9];
  wire xtal_in_use = pins_s2_q[10];
  wire slow_tick   = tick_bus.tick;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_q;
  logic        read_req_q;
  logic [7:0]  cal_q;
  logic [23:0] alarm_q;
  logic [3:0]  latch_q;
  logic [3:0]  mask_q;
  logic        cause_q;
  logic [23:0] stage_min_q;
  logic [15:0] stage_sec_q;
  logic        load_pend_q;
  write_seq_t  seq_q;
  logic [23:0] buf_min_q;
  logic [15:0] buf_sec_q;
  logic [20:0] sub_q;
  logic [23:0] min_q;
  logic [7:0]  rdata_q;

  // Byte pick of a 24-bit value, used by both counter and alarm reads
  function automatic logic [7:0] byte_of(input logic [23:0] v, input logic [1:0] idx);
    byte_of = v[idx*8 +: 8];
  endfunction

  // Address decode
  wire wr_ctrl  = wstb && addr == `RTC_A_CTRL;
  wire wr_rreq  = wstb && addr == `RTC_A_READREQ;
  wire wr_mh    = wstb && addr == `RTC_A_MIN_HIGH;
  wire wr_mm    = wstb && addr == `RTC_A_MIN_MID;
  wire wr_ml    = wstb && addr == `RTC_A_MIN_LOW;
  wire wr_sh    = wstb && addr == `RTC_A_SEC_HIGH;
  wire wr_sm    = wstb && addr == `RTC_A_SEC_MID;
  wire wr_cal   = wstb && addr == `RTC_A_CAL;
  wire wr_ah    = wstb && addr == `RTC_A_ALM_HIGH;
  wire wr_am    = wstb && addr == `RTC_A_ALM_MID;
  wire wr_al    = wstb && addr == `RTC_A_ALM_LOW;
  wire wr_mask  = wstb && addr == `RTC_A_IRQ_MASK;
  wire wr_cause = wstb && addr == `RTC_A_CAUSE;
  wire rd_latch = rstb && addr == `RTC_A_IRQ_LATCH;

  // ----------------------------------------------------------------
  // Counters and calibration
  // ----------------------------------------------------------------
  // Positive correction shortens the minute, negative lengthens it
  localparam logic [20:0] NOMINAL_LAST = 21'(MINUTE_TICKS - 1);
  wire [20:0] cal_mag   = {14'h0000, cal_q[6:0]};
  wire [20:0] last_tick = cal_q[7] ? NOMINAL_LAST + cal_mag
                                   : NOMINAL_LAST - cal_mag;
  wire        wrap      = slow_tick && sub_q >= last_tick;
  wire        do_load   = slow_tick && load_pend_q;
  wire [23:0] min_next  = min_q + 24'h000001;
  wire        alarm_hit = wrap && ctrl_q[`RTC_F_ALARM_EN] && min_next == alarm_q;

  // Counters only move on slow ticks; a pending load takes the tick
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sub_q <= '0;
      min_q <= '0;
    end else if (do_load) begin
      sub_q <= {stage_sec_q, 5'h00};
      min_q <= stage_min_q;
    end else if (wrap) begin
      sub_q <= '0;
      min_q <= min_next;
    end else if (slow_tick) begin
      sub_q <= sub_q + 21'h000001;
    end
  end

  // ----------------------------------------------------------------
  // Counter read buffer
  // ----------------------------------------------------------------
  // Copy on a tick edge, taking the counters as they stand just before that tick steps them
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      read_req_q <= 1'b0;
      buf_min_q  <= '0;
      buf_sec_q  <= '0;
    end else begin
      if (slow_tick && read_req_q) begin
        buf_min_q  <= min_q;
        buf_sec_q  <= sub_q[20:5];
        read_req_q <= 1'b0;
      end else if (wr_rreq && wdata[0]) begin
        read_req_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter load sequence
  // ----------------------------------------------------------------
  // A write out of order drops back to idle; minutes high restarts
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      seq_q       <= WS_IDLE;
      stage_min_q <= '0;
      stage_sec_q <= '0;
      load_pend_q <= 1'b0;
    end else begin
      if (wr_mh) stage_min_q[23:16] <= wdata;
      if (wr_mm) stage_min_q[15:8]  <= wdata;
      if (wr_ml) stage_min_q[7:0]   <= wdata;
      if (wr_sh) stage_sec_q[15:8]  <= wdata;
      if (wr_sm) stage_sec_q[7:0]   <= wdata;
      if (do_load) load_pend_q <= 1'b0;
      if (wr_mh) begin
        seq_q <= WS_MIN_HIGH;
      end else if (wstb && (wr_mm || wr_ml || wr_sh || wr_sm)) begin
        unique case (seq_q)
          WS_MIN_HIGH: seq_q <= wr_mm ? WS_MIN_MID : WS_IDLE;
          WS_MIN_MID:  seq_q <= wr_ml ? WS_MIN_LOW : WS_IDLE;
          WS_MIN_LOW:  seq_q <= wr_sh ? WS_SEC_HIGH : WS_IDLE;
          WS_SEC_HIGH: begin
            seq_q <= WS_IDLE;
            if (wr_sm) load_pend_q <= 1'b1;
          end
          WS_IDLE:     seq_q <= WS_IDLE;
          default:     seq_q <= WS_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Control, calibration, alarm and mask registers
  // ----------------------------------------------------------------
  // The fail marker can be set by software but only reset clears it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_q  <= `RTC_R_CTRL;
      cal_q   <= `RTC_R_CAL;
      alarm_q <= '0;
      mask_q  <= `RTC_R_MASK;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wdata & 8'h3f;
        ctrl_q[`RTC_F_FAIL_MARK] <= ctrl_q[`RTC_F_FAIL_MARK] | wdata[`RTC_F_FAIL_MARK];
      end
      if (wr_cal)  cal_q   <= wdata;
      if (wr_ah)   alarm_q[23:16] <= wdata;
      if (wr_am)   alarm_q[15:8]  <= wdata;
      if (wr_al)   alarm_q[7:0]   <= wdata;
      if (wr_mask) mask_q  <= wdata[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt latches and wake cause
  // ----------------------------------------------------------------
  wire [3:0] irq_set;
  assign irq_set[`RTC_F_IRQ_TICK]   = wrap;
  assign irq_set[`RTC_F_IRQ_ALARM]  = alarm_hit;
  assign irq_set[`RTC_F_IRQ_CHG_OK] = reach_ev;
  assign irq_set[`RTC_F_IRQ_LOST]   = lost_ev;

  // Reading the latch clears it; a set in the same cycle survives
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      latch_q <= '0;
      cause_q <= 1'b0;
    end else begin
      latch_q <= (rd_latch ? 4'h0 : latch_q) | irq_set;
      if (alarm_hit && !op_mode) cause_q <= 1'b1;
      else if (wr_cause && wdata[0]) cause_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Supply, charger and output pins
  // ----------------------------------------------------------------
  wire force_bup = ctrl_q[`RTC_F_FORCE_BUP];
  supply_sel_t    supply_d;
  system_source_t source_d;

  assign supply_d = sys_good ? ((force_bup && rtc_por_ok) ? SUP_BACKUP : SUP_SYSTEM)
                             : (rtc_por_ok ? SUP_BACKUP : SUP_HIZ);
  assign source_d = bat_ok  ? SRC_BATTERY :
                    chg_det ? SRC_CHARGER :
                    vbus_det ? SRC_VBUS : SRC_BACKUP;

  wire chg_en   = ctrl_q[`RTC_F_CHG_EN] && bat_above && bup_low;
  wire chg_hp   = chg_en && op_mode;
  wire chg_lp   = chg_en && !op_mode && ctrl_q[`RTC_F_OFF_KEEP];
  wire out1_d   = op_mode && tick_bus.level;
  wire out2_d   = out1_d && !ctrl_q[`RTC_F_OUT2_DIS];
  wire irq_any  = |(latch_q & ~mask_q);

  // All pins leave from flops; source holds while RTC reset is low
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rtc_supply_sel    <= SUP_HIZ;
      system_source     <= SRC_BACKUP;
      charger_on        <= 1'b0;
      charger_low_power <= 1'b0;
      slow_clock_out1   <= 1'b0;
      slow_clock_out2   <= 1'b0;
      power_on_req      <= 1'b0;
      host_irq_n        <= 1'b1;
    end else begin
      rtc_supply_sel    <= supply_d;
      if (rtc_por_ok) system_source <= source_d;
      charger_on        <= chg_hp || chg_lp;
      charger_low_power <= chg_lp;
      slow_clock_out1   <= out1_d;
      slow_clock_out2   <= out2_d;
      power_on_req      <= alarm_hit && !op_mode;
      host_irq_n        <= ~irq_any;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Counter addresses return the buffer, never the live counters
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (addr)
      `RTC_A_CTRL:      rd_mux = ctrl_q;
      `RTC_A_READREQ:   rd_mux = {7'h00, read_req_q};
      `RTC_A_MIN_HIGH:  rd_mux = byte_of(buf_min_q, 2'd2);
      `RTC_A_MIN_MID:   rd_mux = byte_of(buf_min_q, 2'd1);
      `RTC_A_MIN_LOW:   rd_mux = byte_of(buf_min_q, 2'd0);
      `RTC_A_SEC_HIGH:  rd_mux = buf_sec_q[15:8];
      `RTC_A_SEC_MID:   rd_mux = buf_sec_q[7:0];
      `RTC_A_CAL:       rd_mux = cal_q;
      `RTC_A_ALM_HIGH:  rd_mux = byte_of(alarm_q, 2'd2);
      `RTC_A_ALM_MID:   rd_mux = byte_of(alarm_q, 2'd1);
      `RTC_A_ALM_LOW:   rd_mux = byte_of(alarm_q, 2'd0);
      `RTC_A_IRQ_LATCH: rd_mux = {4'h0, latch_q};
      `RTC_A_IRQ_MASK:  rd_mux = {4'h0, mask_q};
      `RTC_A_STATUS:    rd_mux = {5'h00, charger_on, op_mode, xtal_in_use};
      `RTC_A_CAUSE:     rd_mux = {7'h00, cause_q};
      default:          rd_mux = 8'h00;
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge clock or posedge rst) begin
    if (rst) rdata_q <= 8'h00;
    else     rdata_q <= rstb ? rd_mux : 8'h00;
  end

  assign rdata = rdata_q;
endmodule
`default_nettype wire

// ---- rtc_defs.svh ----
// Register offsets, field positions, reset values and counts of the RTC domain
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH
// Register offsets (word index on the plain register port)
`define RTC_A_CTRL      5'h00
`define RTC_A_READREQ   5'h01
`define RTC_A_MIN_HIGH  5'h02
`define RTC_A_MIN_MID   5'h03
`define RTC_A_MIN_LOW   5'h04
`define RTC_A_SEC_HIGH  5'h05
`define RTC_A_SEC_MID   5'h06
`define RTC_A_CAL       5'h07
`define RTC_A_ALM_HIGH  5'h08
`define RTC_A_ALM_MID   5'h09
`define RTC_A_ALM_LOW   5'h0a
`define RTC_A_IRQ_LATCH 5'h0b
`define RTC_A_IRQ_MASK  5'h0c
`define RTC_A_STATUS    5'h0d
`define RTC_A_CAUSE     5'h0e
// Control register fields
`define RTC_F_ALARM_EN   0
`define RTC_F_CHG_EN     1
`define RTC_F_OFF_KEEP   2
`define RTC_F_FAIL_MARK  3
`define RTC_F_OUT2_DIS   4
`define RTC_F_FORCE_BUP  5
// Interrupt latch and mask fields
`define RTC_F_IRQ_TICK   0
`define RTC_F_IRQ_ALARM  1
`define RTC_F_IRQ_CHG_OK 2
`define RTC_F_IRQ_LOST   3
// Reset values
`define RTC_R_CTRL       8'h00
`define RTC_R_CAL        8'h00
`define RTC_R_MASK       4'hf
// Timing: 32768 slow periods per second, 60 s per minute
`define RTC_SLOW_HZ      32768
`define RTC_MINUTE_S     60
`define RTC_MINUTE_TICKS (`RTC_SLOW_HZ * `RTC_MINUTE_S)
`endif

// ---- rtc_pkg.sv ----
// Types shared by the RTC backup domain modules
`default_nettype none
package rtc_pkg;
  // Which rail feeds the RTC regulator
  typedef enum logic [1:0] {SUP_HIZ, SUP_SYSTEM, SUP_BACKUP} supply_sel_t;
  // Which source stands behind the system rail
  typedef enum logic [1:0] {SRC_BATTERY, SRC_CHARGER, SRC_VBUS, SRC_BACKUP} system_source_t;
  // Progress through the counter load byte order
  typedef enum logic [2:0] {WS_IDLE, WS_MIN_HIGH, WS_MIN_MID, WS_MIN_LOW, WS_SEC_HIGH} write_seq_t;
endpackage
`default_nettype wire

// ---- slow_tick_if.sv ----
// Interface carrying the sampled slow clock from its sampler to the RTC core
`default_nettype none
interface slow_tick_if;
  logic tick;   // One-cycle pulse per slow rising edge
  logic level;  // Synchronised slow clock level
  modport src (output tick, output level);
  modport dst (input tick, input level);
endinterface
`default_nettype wire

// ---- slow_clock_sampler.sv ----
// Two-flop sampler and rising edge finder for the 32 kHz clock
`default_nettype none
module slow_clock_sampler (
  // System clock and reset
  input  wire logic  clock,
  input  wire logic  rst,
  // Raw slow clock
  input  wire logic  slow_clock,
  // Sampled result
  slow_tick_if.src   tick_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Only s2 reads s1; the edge is taken between s2 and s3
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= slow_clock;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign tick_o.tick  = s2_q & ~s3_q;
  assign tick_o.level = s2_q;
endmodule
`default_nettype wire

// ---- slow_osc_model.sv ----
// Free-running oscillator model, 320 ns period, feeding the slow clock pin
`default_nettype none
module slow_osc_model #(
  parameter int unsigned HALF_NS = 160
) (
  // Oscillator pin
  output logic slow_clock
);
  timeunit 1ns;
  timeprecision 1ps;
  // Runs free; the 7 ns offset keeps its edges clear of the system clock edges
  initial begin
    slow_clock = 1'b0;
    #7;
    forever #(HALF_NS) slow_clock = ~slow_clock;
  end
endmodule
`default_nettype wire

// ---- rtc_backup_domain_checker.sv ----
// Port-level assertions for the RTC backup domain
`default_nettype none
module rtc_backup_domain_checker #(
  parameter int unsigned MINUTE_TICKS = 256
) (
  // Clock and reset
  input wire logic                  clock,
  input wire logic                  rst,
  // Observed pins
  input wire logic                  rstb,
  input wire logic [7:0]            rdata,
  input wire logic                  slow_clock,
  input wire logic                  rtc_supply_por_n,
  input wire logic                  system_supply_por_n,
  input wire logic                  battery_por_n,
  input wire logic                  main_charger_detect,
  input wire logic                  vbus_detect,
  input wire logic                  operating_mode,
  input wire logic                  main_above_backup,
  input wire rtc_pkg::supply_sel_t  rtc_supply_sel,
  input wire rtc_pkg::system_source_t system_source,
  input wire logic                  charger_on,
  input wire logic                  slow_clock_out1,
  input wire logic                  slow_clock_out2,
  input wire logic                  power_on_req,
  input wire logic                  host_irq_n
);
  import rtc_pkg::*;
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  logic [2:0] since_q;
  logic [2:0] op_q;
  logic       op_prev_q;
  wire  [5:0] pins = {main_above_backup, rtc_supply_por_n, battery_por_n, main_charger_detect, vbus_detect,
                      system_supply_por_n};
  // Pin results are only judged once the synchroniser pipeline has refilled
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      since_q   <= 3'h0;
      op_q      <= 3'h0;
      op_prev_q <= 1'b0;
    end else begin
      since_q   <= (since_q == 3'h7) ? since_q : since_q + 3'h1;
      op_q      <= (operating_mode != op_prev_q) ? 3'h0 : (op_q == 3'h7) ? op_q : op_q + 3'h1;
      op_prev_q <= operating_mode;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence pins_quiet;
    since_q == 3'h7 && $past(pins, 2) == $past(pins, 3) && $past(pins, 3) == $past(pins, 4);
  endsequence
  sequence mode_settled;
    since_q == 3'h7 && op_q == 3'h7;
  endsequence
  sequence wake_edge;
    !power_on_req ##1 power_on_req;
  endsequence
  supply_choice_a: assert property (pins_quiet ##0 !$past(pins[0], 3) |->
    rtc_supply_sel == ($past(pins[4], 3) ? SUP_BACKUP : SUP_HIZ)) else $error("rtc rail choice wrong");
  source_order_a: assert property (pins_quiet ##0 $past(pins[4], 3) |-> system_source ==
    ($past(pins[3], 3) ? SRC_BATTERY : $past(pins[2], 3) ? SRC_CHARGER : $past(pins[1], 3) ? SRC_VBUS : SRC_BACKUP))
    else $error("system source priority wrong");
  charger_gate_a: assert property (pins_quiet ##0 !$past(pins[5], 3) |-> !charger_on)
    else $error("charger on with battery below backup");
  out_off_a: assert property (mode_settled ##0 !operating_mode |-> !slow_clock_out1 && !slow_clock_out2)
    else $error("slow outputs driven in off mode");
  out_copy_a: assert property (mode_settled ##0 operating_mode |-> slow_clock_out1 == $past(slow_clock, 3))
    else $error("slow output one does not follow slow clock");
  out2_sub_a: assert property (slow_clock_out2 |-> slow_clock_out1)
    else $error("slow output two active alone");
  wake_mode_a: assert property (mode_settled ##0 operating_mode |-> !power_on_req)
    else $error("power on request in operating mode");
  wake_pulse_a: assert property (wake_edge |=> !power_on_req [*3])
    else $error("power on request longer than one cycle");
  rdata_idle_a: assert property (!$past(rstb) |-> rdata == 8'h00)
    else $error("read data outside read answer cycle");
  reset_vals_a: assert property ($fell(rst) |-> host_irq_n && rdata == 8'h00 && !power_on_req &&
    rtc_supply_sel == SUP_HIZ && system_source == SRC_BACKUP) else $error("reset values wrong");
endmodule
bind rtc_backup_domain rtc_backup_domain_checker #(.MINUTE_TICKS(MINUTE_TICKS)) checker_i (
  .clock(clock), .rst(rst), .rstb(rstb), .rdata(rdata), .slow_clock(slow_clock),
  .rtc_supply_por_n(rtc_supply_por_n), .system_supply_por_n(system_supply_por_n), .battery_por_n(battery_por_n),
  .main_charger_detect(main_charger_detect), .vbus_detect(vbus_detect), .operating_mode(operating_mode),
  .main_above_backup(main_above_backup), .rtc_supply_sel(rtc_supply_sel), .system_source(system_source),
  .charger_on(charger_on), .slow_clock_out1(slow_clock_out1), .slow_clock_out2(slow_clock_out2),
  .power_on_req(power_on_req), .host_irq_n(host_irq_n));
`default_nettype wire

// ---- rtc_backup_domain_tb_top.sv ----
// Self-checking testbench for the RTC backup domain
`include "rtc_defs.svh"
`default_nettype none
module rtc_backup_domain_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rtc_pkg::*;
  // ----------------------------------------
  // Signals and design
  // ----------------------------------------
  localparam int unsigned TICKS = 256;
  logic           clock, rst, wstb, rstb, slow, rtc_ok, sys_ok, bat_ok, chg, vbus, op, xtal;
  logic           above, below, at_lvl, hyst, chg_on, chg_lp, out1, out2, pwr, irq_n;
  logic           saw_req = 1'b0;
  logic [4:0]     addr;
  logic [7:0]     wdata, rdata, got;
  supply_sel_t    sel;
  system_source_t src;
  int             err_count, compares, n, hi1, hi2;
  logic [2:0]     src_pins [4] = '{3'b111, 3'b011, 3'b001, 3'b000};
  logic [7:0]     load [5] = '{8'h00, 8'h00, 8'h10, 8'h00, 8'h00};
  rtc_backup_domain #(.MINUTE_TICKS(TICKS)) dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
    .wstb(wstb), .rstb(rstb), .rdata(rdata), .slow_clock(slow), .rtc_supply_por_n(rtc_ok),
    .system_supply_por_n(sys_ok), .battery_por_n(bat_ok), .main_charger_detect(chg), .vbus_detect(vbus),
    .operating_mode(op), .xtal_selected(xtal), .main_above_backup(above), .backup_below_threshold(below),
    .backup_at_level(at_lvl), .backup_below_hyst(hyst), .rtc_supply_sel(sel), .system_source(src),
    .charger_on(chg_on), .charger_low_power(chg_lp), .slow_clock_out1(out1), .slow_clock_out2(out2),
    .power_on_req(pwr), .host_irq_n(irq_n));
  slow_osc_model osc (.slow_clock(slow));
  // Clock and wake request monitor
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) if (pwr === 1'b1) saw_req <= 1'b1;
  // ----------------------------------------
  // Bus tasks and comparisons
  // ----------------------------------------
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wstb  <= 1'b1;
    @(posedge clock);
    wstb  <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clock);
    addr <= a;
    rstb <= 1'b1;
    @(posedge clock);
    rstb <= 1'b0;
    @(posedge clock);
    got = rdata;
  endtask
  task automatic check8(input logic [7:0] act, input logic [7:0] exp);
    compares++;
    if (act !== exp) begin
      err_count++;
      $display("[FAIL] %0t ns: value %h, expected %h", $time, act, exp);
    end
  endtask
  task automatic check1(input logic act, input logic exp);
    compares++;
    if (act !== exp) begin
      err_count++;
      $display("[FAIL] %0t ns: flag %b, expected %b", $time, act, exp);
    end
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
    rd(a);
    check8(got, exp);
  endtask
  // Bounded wait for the host interrupt; n returns the cycles spent
  task automatic wait_irq(input int limit);
    n = 0;
    while (irq_n !== 1'b0 && n < limit) begin
      @(posedge clock);
      n++;
    end
  endtask
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Watchdog sized well past the three simulated minutes
  initial begin
    repeat (14000) @(posedge clock);
    err_count++;
    end_of_test();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {wstb, rstb, addr, wdata, rst} = 16'h0001;
    {rtc_ok, sys_ok, bat_ok, op, above, below} = 6'h3f;
    {chg, vbus, xtal, at_lvl, hyst} = 5'h00;
    cyc(16);
    rst <= 1'b0;
    cyc(4);
    rdchk(`RTC_A_CTRL, `RTC_R_CTRL);
    rdchk(`RTC_A_CAL, `RTC_R_CAL);
    rdchk(`RTC_A_IRQ_MASK, {4'h0, `RTC_R_MASK});
    rdchk(`RTC_A_CAUSE, 8'h00);
    rdchk(5'h1f, 8'h00);
    rdchk(`RTC_A_STATUS, 8'h02);
    xtal <= 1'b1;
    cyc(6);
    rdchk(`RTC_A_STATUS, 8'h03);
    // Control bits, sticky fail marker, charger gate and forced backup rail
    wr(`RTC_A_CTRL, 8'hff);
    cyc(40);
    rdchk(`RTC_A_CTRL, 8'h3f);
    check1(chg_on, 1'b1);
    check1(chg_lp, 1'b0);
    check8({6'h00, sel}, 8'h02);
    wr(`RTC_A_CTRL, 8'h00);
    cyc(40);
    rdchk(`RTC_A_CTRL, 8'h08);
    check1(chg_on, 1'b0);
    check8({6'h00, sel}, 8'h01);
    sys_ok <= 1'b0;
    cyc(6);
    check8({6'h00, sel}, 8'h02);
    rtc_ok <= 1'b0;
    cyc(6);
    check8({6'h00, sel}, 8'h00);
    {rtc_ok, sys_ok} <= 2'b11;
    for (int i = 0; i < 4; i++) begin
      {bat_ok, chg, vbus} <= src_pins[i];
      cyc(6);
      check8({6'h00, src}, 8'(i));
    end
    bat_ok <= 1'b1;
    // Second slow output held off by its disable bit
    wr(`RTC_A_CTRL, 8'h10);
    cyc(40);
    {hi1, hi2} = 64'h0;
    repeat (24) begin
      @(posedge clock);
      hi1 += int'(out1 === 1'b1);
      hi2 += int'(out2 === 1'b1);
    end
    check1(hi1 > 0 && hi2 == 0, 1'b1);
    wr(`RTC_A_CTRL, 8'h00);
    wr(`RTC_A_CAL, 8'h85);
    rdchk(`RTC_A_CAL, 8'h85);
    // Backup charge flags: lost is masked, ok is not
    rd(`RTC_A_IRQ_LATCH);
    wr(`RTC_A_IRQ_MASK, 8'h0b);
    hyst <= 1'b1;
    cyc(8);
    check1(irq_n, 1'b1);
    rdchk(`RTC_A_IRQ_LATCH, 8'h08);
    at_lvl <= 1'b1;
    cyc(8);
    check1(irq_n, 1'b0);
    rdchk(`RTC_A_IRQ_LATCH, 8'h04);
    cyc(3);
    check1(irq_n, 1'b1);
    // Counter load in off mode, charger kept in low power, alarm one minute later wakes the device
    op <= 1'b0;
    wr(`RTC_A_IRQ_MASK, 8'h0c);
    wr(`RTC_A_ALM_HIGH, 8'h00);
    wr(`RTC_A_ALM_MID, 8'h00);
    wr(`RTC_A_ALM_LOW, 8'h11);
    cyc(40);
    wr(`RTC_A_CTRL, 8'h07);
    repeat (2) begin
      for (int i = 0; i < 5; i++) wr(5'(`RTC_A_MIN_HIGH + i), load[i]);
      cyc(72);
    end
    check1(chg_lp, 1'b1);
    wait_irq(3000);
    check1(irq_n, 1'b0);
    rdchk(`RTC_A_IRQ_LATCH, 8'h03);
    check1(saw_req, 1'b1);
    rdchk(`RTC_A_CAUSE, 8'h01);
    wr(`RTC_A_CAUSE, 8'h01);
    rdchk(`RTC_A_CAUSE, 8'h00);
    wr(`RTC_A_READREQ, 8'h01);
    n = 0;
    do begin
      rd(`RTC_A_READREQ);
      n++;
    end while (got[0] !== 1'b0 && n < 40);
    check8(got, 8'h00);
    cyc(32);
    rdchk(`RTC_A_MIN_HIGH, 8'h00);
    rdchk(`RTC_A_MIN_MID, 8'h00);
    rdchk(`RTC_A_MIN_LOW, 8'h11);
    // Next minute lasts 256 + 5 slow periods with the negative correction
    wait_irq(3000);
    rd(`RTC_A_IRQ_LATCH);
    cyc(2); // Cleared latch must reach the pin first
    wait_irq(3000);
    check1(n >= 2076 && n <= 2096, 1'b1);
    rdchk(`RTC_A_IRQ_LATCH, 8'h01);
    // A second power-on reset clears the fail marker
    rst <= 1'b1;
    cyc(4);
    rst <= 1'b0;
    cyc(4);
    rdchk(`RTC_A_CTRL, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
